// ==== dv/operator_model.sv ====
// Purpose: Operator model driving run, resets, undervoltage and terminals
// Assumes: Levels come from the bench at the falling edge of ref_clk
// Notes:   Unused terminals sit on with no function, so a stray guard shows
`timescale 1ns/1ps
`default_nettype none
module operator_model
	import start_guard_pkg::*;
(
	input  wire logic [4:0]            lv,
	input  wire logic [2:0]            gp,
	output var  ctl_in_s               ctl,
	output logic [NUM_INPUTS-1:0]      terminals,
	output var  fsel_t                 fsel [NUM_INPUTS]
);
	// Levels pass through; the bench may already hold run during reset, so powerup sees it
	assign ctl = '{lv[4], lv[3], lv[2], lv[1]};
	// Only the chosen terminal carries option 13 and the guard level
	always_comb begin
		for (int i = 0; i < NUM_INPUTS; i++) begin
			fsel[i] = (i == int'(gp)) ? OPT_START_GUARD : OPT_NONE;
			terminals[i] = (i == int'(gp)) ? lv[0] : 1'b1;
		end
	end
endmodule : operator_model
`default_nettype wire

// ==== dv/test_unattended_start_guard.sv ====
// Purpose: Self-checking bench for the unattended start guard
// Assumes: Status is settled two cycles after a level change
// Notes:   Levels packed as {run, reset terminal, keypad, undervoltage, guard}
`timescale 1ns/1ps
`default_nettype none
module test_unattended_start_guard;
	import start_guard_pkg::*;
	localparam drive_out_s RUN  = '{1'b1, 1'b0, TRIP_CODE_NONE};
	localparam drive_out_s STOP = '{1'b0, 1'b0, TRIP_CODE_NONE};
	localparam drive_out_s GT   = '{1'b0, 1'b1, START_GUARD_TRIP};
	localparam drive_out_s UV   = '{1'b0, 1'b1, UNDERVOLT_TRIP};
	logic                  ref_clk = 1'b0;
	logic                  rst = 1'b1;
	logic [4:0]            lv = 5'h00;
	logic [2:0]            gp = 3'h0;
	ctl_in_s               ctl;
	logic [NUM_INPUTS-1:0] terminals;
	fsel_t                 fsel [NUM_INPUTS];
	drive_out_s            status;
	int                    num_errors = 0;
	int                    n_checks = 0;
	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;
	operator_model op (.lv(lv), .gp(gp), .ctl(ctl), .terminals(terminals), .fsel(fsel));
	unattended_start_guard dut (.ref_clk(ref_clk), .rst(rst), .ctl(ctl),
		.terminals(terminals), .input_function_select(fsel), .status(status));
	task automatic check(input drive_out_s exp);
		n_checks++;
		if (status !== exp) begin
			num_errors++;
			$display("[FAIL] %0t status %h expected %h", $time, status, exp);
		end
	endtask : check
	// Change levels, let two edges land, then judge
	task automatic apply(input logic [4:0] l, input drive_out_s exp);
		@(negedge ref_clk) lv = l;
		repeat (2) @(negedge ref_clk);
		check(exp);
	endtask : apply
	// Power-on reset of 16 cycles with the levels already present
	task automatic pwr(input logic [4:0] l, input logic [2:0] g, input drive_out_s exp);
		@(negedge ref_clk) rst = 1'b1;
		lv = l;
		gp = g;
		repeat (16) @(negedge ref_clk);
		rst = 1'b0;
		repeat (2) @(negedge ref_clk);
		check(exp);
	endtask : pwr
	task automatic t_no_guard();
		pwr(5'h10, 3'h2, RUN);
		apply(5'h12, UV);
		$display("test no_guard done");
	endtask : t_no_guard
	task automatic t_run_off();
		pwr(5'h11, 3'h7, GT);
		apply(5'h01, STOP);
		apply(5'h11, RUN);
		$display("test run_off done");
	endtask : t_run_off
	task automatic t_resets();
		pwr(5'h11, 3'h0, GT);
		apply(5'h13, GT);
		apply(5'h19, RUN);
		apply(5'h11, RUN);
		pwr(5'h11, 3'h4, GT);
		apply(5'h15, RUN);
		$display("test resets done");
	endtask : t_resets
	task automatic t_undervolt();
		pwr(5'h01, 3'h5, STOP);
		apply(5'h11, RUN);
		apply(5'h13, UV);
		// One-cycle reset pulse so the reset does not also clear the guard trip
		@(negedge ref_clk) lv = 5'h19;
		@(negedge ref_clk) lv = 5'h11;
		repeat (2) @(negedge ref_clk);
		check(GT);
		$display("test undervolt done");
	endtask : t_undervolt
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	initial begin
		t_no_guard();
		t_run_off();
		t_resets();
		t_undervolt();
		results();
	end
	// About 130 cycles are needed; 1000 means a hang
	initial begin
		#25000;
		num_errors++;
		results();
	end
endmodule : test_unattended_start_guard
`default_nettype wire

// ==== rtl/start_guard_pkg.sv ====
// Purpose: Shared constants and carriers for the unattended start guard
// Assumes: One 40 MHz clock, inputs synchronous to it
// Notes:   Trip codes are display codes; option code selects terminal function
package start_guard_pkg;
	localparam int            NUM_INPUTS        = 8;
	localparam int            FSEL_W            = 8;
	localparam logic [7:0]    OPT_START_GUARD   = 8'h0d;   // Option code 13
	localparam logic [7:0]    OPT_NONE          = 8'h00;
	localparam logic [7:0]    TRIP_CODE_NONE    = 8'h00;
	localparam logic [7:0]    START_GUARD_TRIP  = 8'h0d;   // Trip code 13
	localparam logic [7:0]    UNDERVOLT_TRIP    = 8'h09;   // Trip code 9

	typedef logic [FSEL_W-1:0] fsel_t;

	typedef enum {
		ST_POWERUP,
		ST_STOP,
		ST_RUN,
		ST_TRIP_GUARD,
		ST_TRIP_UV
	} guard_state_e;

	// Operator-side control levels
	typedef struct packed {
		logic run_cmd;
		logic reset_terminal_input;
		logic keypad_stop_reset;
		logic undervoltage;
	} ctl_in_s;

	// Drive-side status
	typedef struct packed {
		logic       motor_run;
		logic       alarm;
		logic [7:0] trip_code;
	} drive_out_s;
endpackage : start_guard_pkg

// ==== rtl/terminal_select.sv ====
// Purpose: Picks the start guard level from the programmable input terminals
// Assumes: Terminal levels are synchronous and active high
// Notes:   Several terminals given the guard function are ORed together
`timescale 1ns/1ps
`default_nettype none
module terminal_select
	import start_guard_pkg::*;
(
	input  wire logic [NUM_INPUTS-1:0] terminals,
	input  wire fsel_t                 fsel [NUM_INPUTS],
	output logic                       guard_level
);
	logic [NUM_INPUTS-1:0] hit;

	// One comparator per terminal
	genvar i;
	generate
		for (i = 0; i < NUM_INPUTS; i++) begin : g_sel
			assign hit[i] = terminals[i] && (fsel[i] == OPT_START_GUARD);
		end
	endgenerate

	assign guard_level = |hit;
endmodule : terminal_select
`default_nettype wire

// ==== rtl/unattended_start_guard.sv ====
// Purpose: Stops the drive starting by itself when run is held at power-on
// Assumes: rst is the power-on reset; all inputs synchronous to ref_clk
// Notes:   The guard check is armed only at the first clock after reset and
//          again when an undervoltage trip is cleared by reset
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Guard off and run held at power-on: motor runs right after powerup.
// - Guard on: no automatic start at powerup.
// - Guard on and run seen right after power-on: enter guard trip.
// - In guard trip, show start guard trip code and assert alarm.
// - Withdrawing run clears the guard trip and allows running again.
// - Reset terminal or keypad stop/reset also clears the guard trip.
// - Cleared by reset with run still held: motor restarts at once.
// - After undervoltage trip cleared by reset, guard check still applies.
// - Guard asserted: a pending run is not resumed at powerup.
// - Guard deasserted: pending run is resumed at powerup.
// - Guard function sits on any input whose selector equals 13.
module unattended_start_guard
	import start_guard_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	input  wire ctl_in_s               ctl,
	input  wire logic [NUM_INPUTS-1:0] terminals,
	input  wire fsel_t                 input_function_select [NUM_INPUTS],
	output var  drive_out_s            status
);
	typedef struct packed {
		guard_state_e st;
		drive_out_s   out;
	} state_s;

	state_s cur;
	state_s next_cur;
	logic   start_guard;
	logic   do_reset;

	terminal_select u_sel (
		.terminals   (terminals),
		.fsel        (input_function_select),
		.guard_level (start_guard)
	);

	assign do_reset = ctl.reset_terminal_input || ctl.keypad_stop_reset;
	assign status   = cur.out;

	// Next-state logic; outputs are registered with the state
	always_comb begin
		next_cur = cur;
		case (cur.st)
			ST_POWERUP: begin
				// First clock after reset release decides power-on behaviour
				if (ctl.run_cmd && start_guard)
					next_cur.st = ST_TRIP_GUARD;
				else if (ctl.run_cmd)
					next_cur.st = ST_RUN;
				else
					next_cur.st = ST_STOP;
			end
			ST_STOP: begin
				if (ctl.undervoltage)
					next_cur.st = ST_TRIP_UV;
				else if (ctl.run_cmd)
					next_cur.st = ST_RUN;
			end
			ST_RUN: begin
				if (ctl.undervoltage)
					next_cur.st = ST_TRIP_UV;
				else if (!ctl.run_cmd)
					next_cur.st = ST_STOP;
			end
			ST_TRIP_GUARD: begin
				// Reset with run held restarts at once, no new edge needed
				if (do_reset && ctl.run_cmd)
					next_cur.st = ST_RUN;
				else if (do_reset || !ctl.run_cmd)
					next_cur.st = ST_STOP;
			end
			ST_TRIP_UV: begin
				// Recovery re-arms the guard check, like a fresh powerup
				if (do_reset && !ctl.undervoltage)
					next_cur.st = ST_POWERUP;
			end
			default: next_cur.st = ST_STOP;
		endcase
		next_cur.out.motor_run = (next_cur.st == ST_RUN);
		next_cur.out.alarm     = (next_cur.st == ST_TRIP_GUARD) ||
		                         (next_cur.st == ST_TRIP_UV);
		case (next_cur.st)
			ST_TRIP_GUARD: next_cur.out.trip_code = START_GUARD_TRIP;
			ST_TRIP_UV:    next_cur.out.trip_code = UNDERVOLT_TRIP;
			default:       next_cur.out.trip_code = TRIP_CODE_NONE;
		endcase
	end

	// State register; reset lands in powerup so the next edge samples inputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur.st  <= ST_POWERUP;
			cur.out <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	property p_guard_trip;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_POWERUP && ctl.run_cmd && start_guard) |=>
			(status.alarm && status.trip_code == START_GUARD_TRIP && !status.motor_run);
	endproperty
	a_guard_trip: assert property (p_guard_trip) else $error("guard trip missed");

	property p_no_guard_run;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_POWERUP && ctl.run_cmd && !start_guard) |=> status.motor_run;
	endproperty
	a_no_guard_run: assert property (p_no_guard_run) else $error("auto start missing");

	property p_alarm_code;
		@(posedge ref_clk) disable iff (rst)
		(status.trip_code == START_GUARD_TRIP) |-> (status.alarm && !status.motor_run);
	endproperty
	a_alarm_code: assert property (p_alarm_code) else $error("alarm code mismatch");

	property p_clear_run_off;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_TRIP_GUARD && !ctl.run_cmd) |=> !status.alarm;
	endproperty
	a_clear_run_off: assert property (p_clear_run_off) else $error("run off no clear");

	sequence s_trip_reset_run;
		cur.st == ST_TRIP_GUARD && do_reset && ctl.run_cmd;
	endsequence
	property p_reset_restart;
		@(posedge ref_clk) disable iff (rst)
		s_trip_reset_run |=> (status.motor_run && !status.alarm);
	endproperty
	a_reset_restart: assert property (p_reset_restart) else $error("no restart");

	property p_reset_clear;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_TRIP_GUARD && do_reset) |=> !status.alarm;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset no clear");

	sequence s_uv_cleared;
		cur.st == ST_TRIP_UV && do_reset && !ctl.undervoltage;
	endsequence
	property p_uv_rearm;
		@(posedge ref_clk) disable iff (rst)
		s_uv_cleared ##1 (ctl.run_cmd && start_guard) |=>
			(status.trip_code == START_GUARD_TRIP);
	endproperty
	a_uv_rearm: assert property (p_uv_rearm) else $error("guard not rearmed");

	property p_guard_no_start;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_POWERUP && start_guard) |=> !status.motor_run;
	endproperty
	a_guard_no_start: assert property (p_guard_no_start) else $error("guarded start");

	property p_first_sample;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_POWERUP && !ctl.run_cmd) |=> (cur.st == ST_STOP && !status.alarm);
	endproperty
	a_first_sample: assert property (p_first_sample) else $error("bad first sample");

	// Run alone never lifts a guard trip; only a reset or run off may
	property p_trip_holds;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_TRIP_GUARD && ctl.run_cmd && !do_reset) |=>
			(status.alarm && status.trip_code == START_GUARD_TRIP && !status.motor_run);
	endproperty
	a_trip_holds: assert property (p_trip_holds) else $error("run lifted guard trip");

	// Keypad pin checked directly, so a broken reset merge still shows
	property p_keypad_clear;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_TRIP_GUARD && ctl.keypad_stop_reset) |=> !status.alarm;
	endproperty
	a_keypad_clear: assert property (p_keypad_clear) else $error("keypad no clear");

	// Reset terminal checked directly as well
	property p_terminal_clear;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_TRIP_GUARD && ctl.reset_terminal_input) |=> !status.alarm;
	endproperty
	a_terminal_clear: assert property (p_terminal_clear) else $error("terminal no clear");

	// Alarm and motor drive must never be seen together
	property p_alarm_no_run;
		@(posedge ref_clk) disable iff (rst)
		status.alarm |-> !status.motor_run;
	endproperty
	a_alarm_no_run: assert property (p_alarm_no_run) else $error("alarm while running");

	// Undervoltage while stopped or running trips with its own code
	property p_uv_trip;
		@(posedge ref_clk) disable iff (rst)
		(cur.st inside {ST_STOP, ST_RUN} && ctl.undervoltage) |=>
			(status.alarm && status.trip_code == UNDERVOLT_TRIP);
	endproperty
	a_uv_trip: assert property (p_uv_trip) else $error("undervoltage not tripped");

	// Clearing undervoltage goes back through the power-on check, idle
	property p_uv_to_check;
		@(posedge ref_clk) disable iff (rst)
		s_uv_cleared |=> (cur.st == ST_POWERUP && !status.alarm && !status.motor_run);
	endproperty
	a_uv_to_check: assert property (p_uv_to_check) else $error("no powerup recheck");

	// The power-on decision takes exactly one clock, never more
	property p_powerup_once;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_POWERUP) |=> (cur.st != ST_POWERUP);
	endproperty
	a_powerup_once: assert property (p_powerup_once) else $error("powerup lingered");

	// Once out of a trip, a run level starts the motor normally
	property p_stop_start;
		@(posedge ref_clk) disable iff (rst)
		(cur.st == ST_STOP && ctl.run_cmd && !ctl.undervoltage) |=> status.motor_run;
	endproperty
	a_stop_start: assert property (p_stop_start) else $error("run from stop missing");
endmodule : unattended_start_guard
`default_nettype wire
